// ### design/pcflow_pkg.sv
// Purpose: Shared constants and carriers for program flow and addressing
// Assumes: Single core clock, synchronous active-low reset
// Notes: Operation codes are driven by the instruction decoder
package pcflow_pkg;
  localparam int PC_W = 13;
  localparam int LOW_W = 8;
  localparam int HIGH_W = 5;
  localparam int JUMP_W = 11;
  localparam int PAGE_LSB = 3;
  localparam int PAGE_MSB = 4;
  localparam int STACK_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int DADDR_W = 9;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [LOW_W-1:0] LATCH_RESET = 8'h00;
  localparam logic [LOW_W-1:0] PTR_RESET = 8'h00;
  localparam logic [LOW_W-1:0] SELF_READ_VALUE = 8'h00;

  typedef enum logic [2:0] {
    OP_STEP = 3'b000,
    OP_JUMP = 3'b001,
    OP_CALL = 3'b010,
    OP_RETURN = 3'b011,
    OP_VECTOR = 3'b100,
    OP_HOLD = 3'b101
  } flow_op_e;

  typedef struct packed {
    flow_op_e op;
    logic [JUMP_W-1:0] target;
    logic [PC_W-1:0] vector_addr;
  } flow_cmd_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic indirect;
    logic [LOW_W-1:0] wdata;
  } data_req_s;
endpackage : pcflow_pkg

// ### design/pc_stack_indirect_addr.sv
// Purpose: Program counter, return stack and indirect address former
// Assumes: Decoder gives one flow command per cycle, synchronous inputs
// Notes: Data memory itself lives outside; this block forms its address
//
// Summary of operation
// - 13-bit program counter; low byte read and written by software.
// - Upper five bits unreadable; software writes them only through the high latch.
// - Any reset clears the program counter upper bits.
// - Low byte write loads upper bits from latch bits 4 to 0.
// - Jump or call uses 11 instruction bits plus latch bits 4 and 3.
// - Eight-entry 13-bit stack, pointer hidden from software.
// - Call pushes the program counter plus one; interrupt vector pushes the current one.
// - Any return without a low byte write in the same cycle pops and restores the full 13-bit counter.
// - Pushes and pops leave the high latch unchanged.
// - Stack wraps circularly; ninth push overwrites the first.
// - No overflow or underflow status is given.
// - Indirect register accesses the register the file pointer names.
// - Indirect through itself reads 00h, writes change nothing.
// - Indirect address is bank bit above the 8-bit file pointer.
`timescale 1ns/1ps
module pc_stack_indirect_addr #(
  parameter int DEPTH = pcflow_pkg::STACK_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire pcflow_pkg::flow_cmd_s cmd,
  input wire logic low_byte_wr,
  input wire logic [pcflow_pkg::LOW_W-1:0] low_byte_wdata,
  input wire logic latch_wr,
  input wire logic [pcflow_pkg::LOW_W-1:0] latch_wdata,
  input wire logic ptr_wr,
  input wire logic [pcflow_pkg::LOW_W-1:0] ptr_wdata,
  input wire logic indirect_bank_bit,
  input wire pcflow_pkg::data_req_s dreq,
  input wire logic [pcflow_pkg::LOW_W-1:0] mem_rdata,
  output logic [pcflow_pkg::PC_W-1:0] pc,
  output logic [pcflow_pkg::LOW_W-1:0] pc_low_byte,
  output logic [pcflow_pkg::LOW_W-1:0] pc_high_latch,
  output logic [pcflow_pkg::LOW_W-1:0] file_pointer_reg,
  output logic [pcflow_pkg::DADDR_W-1:0] ind_addr,
  output logic mem_wr_en,
  output logic [pcflow_pkg::LOW_W-1:0] ind_rdata
);
  localparam int PW = $clog2(DEPTH);

  logic [pcflow_pkg::PC_W-1:0] pc_r;
  logic [pcflow_pkg::PC_W-1:0] pc_nxt;
  logic [pcflow_pkg::LOW_W-1:0] latch_r;
  logic [pcflow_pkg::LOW_W-1:0] fsr_r;
  logic [PW-1:0] sp_r;
  logic [PW-1:0] sp_nxt;
  logic [pcflow_pkg::PC_W-1:0] stack_mem [DEPTH];

  wire logic is_call = cmd.op == pcflow_pkg::OP_CALL;
  wire logic is_jump = cmd.op == pcflow_pkg::OP_JUMP;
  wire logic is_ret = cmd.op == pcflow_pkg::OP_RETURN;
  wire logic is_vec = cmd.op == pcflow_pkg::OP_VECTOR;
  wire logic is_hold = cmd.op == pcflow_pkg::OP_HOLD;
  wire logic do_push = is_call || is_vec;
  wire logic [pcflow_pkg::PC_W-1:0] pc_inc = pc_r + 13'h0001;
  wire logic [pcflow_pkg::PC_W-1:0] jump_addr =
    {latch_r[pcflow_pkg::PAGE_MSB:pcflow_pkg::PAGE_LSB], cmd.target};
  wire logic [pcflow_pkg::PC_W-1:0] low_wr_addr =
    {latch_r[pcflow_pkg::HIGH_W-1:0], low_byte_wdata};
  // pop full 13-bit entry
  // Pop on an empty stack wraps and reads a stale entry
  wire logic [PW-1:0] sp_pop = sp_r - 1'b1;
  wire logic [pcflow_pkg::PC_W-1:0] ret_addr = stack_mem[sp_pop];
  wire logic [pcflow_pkg::DADDR_W-1:0] ind_addr_w = {indirect_bank_bit, fsr_r};
  wire logic self_ref = fsr_r == pcflow_pkg::PTR_RESET;

  // Low byte write outranks sequencing, as the write is the instruction
  always_comb begin
    pc_nxt = pc_inc;
    sp_nxt = sp_r;
    if (low_byte_wr) begin
      pc_nxt = low_wr_addr;
    end else begin
      case (cmd.op)
        pcflow_pkg::OP_STEP: pc_nxt = pc_inc;
        pcflow_pkg::OP_JUMP: pc_nxt = jump_addr;
        pcflow_pkg::OP_CALL: pc_nxt = jump_addr;
        pcflow_pkg::OP_RETURN: pc_nxt = ret_addr;
        pcflow_pkg::OP_VECTOR: pc_nxt = cmd.vector_addr;
        pcflow_pkg::OP_HOLD: pc_nxt = pc_r;
        default: pc_nxt = pc_inc;
      endcase
    end
    if (do_push && !low_byte_wr) begin
      sp_nxt = sp_r + 1'b1;
    end else if (is_ret && !low_byte_wr) begin
      sp_nxt = sp_pop;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pc_r <= pcflow_pkg::PC_RESET;
      sp_r <= '0;
    end else begin
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
    end
  end

  // stack storage, hidden pointer
  // Call pushes the return address, vector the interrupted one
  // Entries have no reset; only the pointer is cleared
  always_ff @(posedge clk) begin
    if (do_push && !low_byte_wr) begin
      stack_mem[sp_r] <= is_call ? pc_inc : pc_r;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_r <= pcflow_pkg::LATCH_RESET;
      fsr_r <= pcflow_pkg::PTR_RESET;
    end else begin
      if (latch_wr) latch_r <= latch_wdata;
      if (ptr_wr) fsr_r <= ptr_wdata;
    end
  end

  assign pc = pc_r;
  assign pc_low_byte = pc_r[pcflow_pkg::LOW_W-1:0];
  assign pc_high_latch = latch_r;
  assign file_pointer_reg = fsr_r;
  assign ind_addr = ind_addr_w;
  assign mem_wr_en = dreq.indirect && dreq.wr && !self_ref;
  assign ind_rdata = self_ref ? pcflow_pkg::SELF_READ_VALUE : mem_rdata;

  // Flow checks watch registered outputs one edge after the command; indirect access checks hold in the same cycle, the address check one edge after ptr_wr
  // jump page select
  a_jump_page: assert property (@(posedge clk) disable iff (!rst_n)
    is_jump && !low_byte_wr |=> pc == $past(jump_addr))
    else $error("jump target wrong");
  a_low_write: assert property (@(posedge clk) disable iff (!rst_n)
    low_byte_wr |=> pc[12:8] == $past(latch_r[4:0]))
    else $error("low write high bits wrong");
  a_low_value: assert property (@(posedge clk) disable iff (!rst_n)
    low_byte_wr |=> pc_low_byte == $past(low_byte_wdata))
    else $error("low byte value wrong");
  a_step_inc: assert property (@(posedge clk) disable iff (!rst_n)
    cmd.op == pcflow_pkg::OP_STEP && !low_byte_wr
    |=> pc == $past(pc) + 13'h0001)
    else $error("step did not increment");
  a_call_return: assert property (@(posedge clk) disable iff (!rst_n)
    is_call && !low_byte_wr ##1 is_ret && !low_byte_wr
    |=> pc == $past(pc, 2) + 13'h0001)
    else $error("return address wrong");
  a_vector_load: assert property (@(posedge clk) disable iff (!rst_n)
    is_vec && !low_byte_wr |=> pc == $past(cmd.vector_addr))
    else $error("vector target wrong");
  a_latch_stable: assert property (@(posedge clk) disable iff (!rst_n)
    (do_push || is_ret) && !latch_wr |=> $stable(latch_r))
    else $error("latch changed by stack");
  a_self_read: assert property (@(posedge clk) disable iff (!rst_n)
    self_ref |-> ind_rdata == 8'h00 && !mem_wr_en)
    else $error("self reference not blocked");
  a_ind_write: assert property (@(posedge clk) disable iff (!rst_n)
    dreq.indirect && dreq.wr && !self_ref |-> mem_wr_en)
    else $error("indirect write lost");
  a_ind_addr: assert property (@(posedge clk) disable iff (!rst_n)
    ptr_wr |=> ind_addr[7:0] == $past(ptr_wdata))
    else $error("indirect address wrong");
  a_reset_clear: assert property (@(posedge clk)
    !rst_n |=> pc == 13'h0000)
    else $error("reset did not clear pc");
  a_reset_regs: assert property (@(posedge clk)
    !rst_n |=> pc_high_latch == 8'h00 && file_pointer_reg == 8'h00)
    else $error("reset did not clear registers");
  a_stack_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    do_push && !low_byte_wr && sp_r == 3'h7 |=> sp_r == 3'h0)
    else $error("stack did not wrap");
  a_pop_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    is_ret && !low_byte_wr && sp_r == 3'h0 |=> sp_r == 3'h7)
    else $error("pop did not wrap");
  a_hold_stays: assert property (@(posedge clk) disable iff (!rst_n)
    is_hold && !low_byte_wr |=> $stable(pc))
    else $error("hold changed pc");

  // Main scenarios
  c_call: cover property (@(posedge clk) disable iff (!rst_n) is_call);
  c_vector: cover property (@(posedge clk) disable iff (!rst_n) is_vec);
  c_wrap: cover property (@(posedge clk) disable iff (!rst_n)
    do_push && sp_r == 3'h7);
  c_self: cover property (@(posedge clk) disable iff (!rst_n)
    dreq.indirect && dreq.wr && self_ref);
  c_underflow: cover property (@(posedge clk) disable iff (!rst_n)
    is_ret && sp_r == 3'h0);
endmodule : pc_stack_indirect_addr

// ### tb/data_mem_model.sv
// Purpose: Data memory on the far side of the indirect address
// Assumes: Written on the core clock rising edge
// Notes: Nonzero fill, so a read of location zero stands out
`timescale 1ns/1ps
module data_mem_model (
  input wire logic clk,
  input wire logic [8:0] addr,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [512];
  initial for (int i = 0; i < 512; i++) mem[i] = 8'hA5;
  assign rdata = mem[addr];
  always @(posedge clk) if (we) mem[addr] <= wdata;
endmodule : data_mem_model

// ### tb/pc_stack_indirect_addr_tb.sv
// Purpose: Self-checking bench for program flow and indirect address
// Assumes: Inputs change at the falling edge only
// Notes: One idle hold cycle follows every operation issued through go; call then return runs back to back
`timescale 1ns/1ps
module pc_stack_indirect_addr_tb;
  logic clk = 0, rst_n = 0, low_byte_wr = 0, latch_wr = 0, ptr_wr = 0;
  logic indirect_bank_bit = 0, mem_wr_en;
  logic [7:0] low_byte_wdata = 0, latch_wdata = 0, ptr_wdata = 0;
  logic [7:0] mem_rdata, pc_low_byte, pc_high_latch, file_pointer_reg;
  logic [7:0] ind_rdata;
  logic [8:0] ind_addr;
  logic [12:0] pc, e, stk [8];
  pcflow_pkg::flow_cmd_s cmd = '{pcflow_pkg::OP_HOLD, 11'h0, 13'h0};
  pcflow_pkg::data_req_s dreq = '0;
  int mismatches = 0, num_checks = 0, sp = 0;
  initial forever #50 clk = ~clk;
  pc_stack_indirect_addr pc_stack_indirect_addr_i (.clk, .rst_n, .cmd,
    .low_byte_wr, .low_byte_wdata, .latch_wr, .latch_wdata, .ptr_wr,
    .ptr_wdata, .indirect_bank_bit, .dreq, .mem_rdata, .pc, .pc_low_byte,
    .pc_high_latch, .file_pointer_reg, .ind_addr, .mem_wr_en, .ind_rdata);
  data_mem_model data_mem_model_i (.clk, .addr(ind_addr), .we(mem_wr_en),
    .wdata(dreq.wdata), .rdata(mem_rdata));
  task chk(input string n, input logic [12:0] x, input logic [12:0] g);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task go(input pcflow_pkg::flow_op_e op, input logic [10:0] t);
    cmd.op = op;
    cmd.target = t;
    @(negedge clk);
    // Idle edge after, so no input changes twice in one step
    cmd.op = pcflow_pkg::OP_HOLD;
    {low_byte_wr, latch_wr, ptr_wr} = 3'h0;
    dreq = '0;
    @(negedge clk);
  endtask : go
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // Hang guard
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    complete_run;
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    chk("pc", 13'h0000, pc);
    latch_wr = 1;
    latch_wdata = 8'h15;
    go(pcflow_pkg::OP_HOLD, 0);
    low_byte_wr = 1;
    low_byte_wdata = 8'hFF;
    go(pcflow_pkg::OP_STEP, 0);
    chk("pc", 13'h15FF, pc);
    chk("low", 13'h00FF, pc_low_byte);
    e = pc + 13'h1;
    go(pcflow_pkg::OP_STEP, 0);
    chk("step", e, pc);
    latch_wr = 1;
    latch_wdata = 8'h0F;
    go(pcflow_pkg::OP_HOLD, 0);
    go(pcflow_pkg::OP_JUMP, 11'h123);
    chk("jump", 13'h0923, pc);
    latch_wr = 1;
    latch_wdata = 8'h08;
    go(pcflow_pkg::OP_HOLD, 0);
    for (int i = 0; i < 9; i++) begin
      stk[sp % 8] = pc + 13'h1;
      sp++;
      go(pcflow_pkg::OP_CALL, 11'h100 + 11'(i));
      chk("call", {2'b01, 11'h100 + 11'(i)}, pc);
    end
    // Ninth pop sees the ninth push again
    for (int i = 0; i < 9; i++) begin
      sp--;
      go(pcflow_pkg::OP_RETURN, 0);
      chk("ret", stk[sp % 8], pc);
    end
    chk("latch", 13'h0008, pc_high_latch);
    e = pc;
    cmd.vector_addr = 13'h0004;
    go(pcflow_pkg::OP_VECTOR, 0);
    chk("vec", 13'h0004, pc);
    go(pcflow_pkg::OP_RETURN, 0);
    chk("reti", e, pc);
    // call and return back to back
    e = pc + 13'h1;
    cmd.op = pcflow_pkg::OP_CALL;
    cmd.target = 11'h040;
    @(negedge clk);
    go(pcflow_pkg::OP_RETURN, 0);
    chk("callret", e, pc);
    ptr_wr = 1;
    ptr_wdata = 8'h20;
    indirect_bank_bit = 1;
    go(pcflow_pkg::OP_HOLD, 0);
    chk("ptr", 13'h0020, file_pointer_reg);
    dreq = '{1'b0, 1'b1, 1'b1, 8'h5A};
    #1;
    chk("addr", 13'h0120, ind_addr);
    chk("wen", 13'h1, mem_wr_en);
    go(pcflow_pkg::OP_HOLD, 0);
    dreq = '{1'b1, 1'b0, 1'b1, 8'h00};
    #1;
    chk("rd", 13'h005A, ind_rdata);
    ptr_wr = 1;
    ptr_wdata = 8'h00;
    go(pcflow_pkg::OP_HOLD, 0);
    dreq = '{1'b1, 1'b1, 1'b1, 8'h77};
    #1;
    chk("wen0", 13'h0, mem_wr_en);
    chk("rd0", 13'h0000, ind_rdata);
    go(pcflow_pkg::OP_HOLD, 0);
    rst_n = 0;
    go(pcflow_pkg::OP_HOLD, 0);
    rst_n = 1;
    chk("rst", 13'h0000, pc);
    chk("rlatch", 13'h0000, pc_high_latch);
    complete_run;
  end
endmodule : pc_stack_indirect_addr_tb
